/* hdl/led_target.sv */
// Purpose: write-only serial target, register bank and pwm of a 12-channel led driver
// Assumes: link lines are asynchronous and sampled by clk_i
// Notes:   sink outputs are on/off pwm levels, analog level not modelled
`timescale 1ns/1ns
// Operation
// - answer only to 11011 plus strap bits
// - serve writes only, refuse read bit
// - strap selects two low address bits
// - sample data while clock stably high
// - start: data falls, clock high
// - controller sends address byte msb first
// - pull data low on ninth pulse
// - controller stops after missing acknowledge
// - acknowledge pointer byte, load pointer
// - acknowledge every data byte, msb first
// - stop: data rises, clock high
// - controller leaves data released when idle
// - pointer increments by one per byte
// - shutdown bit zero means software shutdown
// - duty value over 256 sets on-fraction
// - shadows copied on update write of zero
// - scale code selects level or off
// - scale registers 17h..22h, field D5:D0
// - global bit zero is normal operation
// - frequency bit picks 24k or 3.6k
// - reset write of zero restores defaults
// - shutdown keeps register contents
module led_target
   import led_link_pkg::*;
(
   // clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // link
   led_link_if.tgt            link,
   // pins of the device
   input  wire logic [1:0]    addr_strap_i,
   input  wire logic          hw_shutdown_n_i,
   output logic [CHANNELS-1:0] led_sink_outputs_o,
   output logic               pwm_rate_select_o
);
   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_ADDR   = 3'b001,
      S_PTR    = 3'b010,
      S_DATA   = 3'b011,
      S_ACK    = 3'b100,
      S_IGNORE = 3'b101
   } tgt_state_e;

   tgt_state_e             state_q;
   tgt_state_e             next_q;
   logic [2:0]             scl_s;
   logic [2:0]             sda_s;
   logic [1:0]             strap_s1;
   logic [1:0]             strap_s2;
   logic [1:0]             hwsd_s;
   logic [3:0]             bit_cnt_q;
   logic [7:0]             shift_q;
   logic [7:0]             ptr_q;
   logic                   ack_q;
   logic                   soft_shutdown_n_q;
   logic                   global_off_q;
   logic                   pwm_rate_q;
   logic [7:0]             duty_sh_q  [CHANNELS];
   logic [7:0]             duty_act_q [CHANNELS];
   logic [5:0]             scale_sh_q  [CHANNELS];
   logic [5:0]             scale_act_q [CHANNELS];
   logic [8:0]             presc_q;
   logic [7:0]             pwm_cnt_q;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   start_seen;
   logic                   stop_seen;
   logic                   byte_done;
   logic                   wr_stb;
   logic                   upd_stb;
   logic                   soft_rst;
   logic                   out_en;

   // index of a channel from a pointer within a range
   function automatic logic [3:0] chan_idx(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] diff;
      diff = addr - base;
      return diff[3:0];
   endfunction

   // scale codes that turn the sink on; off and disallowed codes leave it dark
   function automatic logic scale_on(input logic [5:0] code);
      return (code >= SCALE_FULL) && (code <= SCALE_7_12);
   endfunction

   // ==========================================================
   // link and pin synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scl_s    <= 3'h7;
         sda_s    <= 3'h7;
         strap_s1 <= 2'h0;
         strap_s2 <= 2'h0;
         hwsd_s   <= 2'h0;
      end else begin
         scl_s    <= {scl_s[1:0], link.scl};
         sda_s    <= {sda_s[1:0], link.sda};
         strap_s1 <= addr_strap_i;
         strap_s2 <= strap_s1;
         hwsd_s   <= {hwsd_s[0], hw_shutdown_n_i};
      end
   end

   // bus events from the second and third stages
   assign scl_rise   = scl_s[1] & ~scl_s[2];
   assign scl_fall   = ~scl_s[1] & scl_s[2];
   assign start_seen = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
   assign stop_seen  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
   assign byte_done  = scl_fall && (bit_cnt_q == 4'h8);
   assign wr_stb     = byte_done && (state_q == S_DATA);
   assign upd_stb    = wr_stb && (ptr_q == REG_UPDATE) && (shift_q == TRIGGER_VALUE);
   assign soft_rst   = wr_stb && (ptr_q == REG_SOFT_RESET) && (shift_q == TRIGGER_VALUE);

   // ==========================================================
   // byte receiver and acknowledge sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q   <= S_IDLE;
         next_q    <= S_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
         ptr_q     <= 8'h00;
         ack_q     <= 1'b0;
      end else if (start_seen) begin
         state_q   <= S_ADDR;
         bit_cnt_q <= 4'h0;
         ack_q     <= 1'b0;
      end else if (stop_seen) begin
         state_q   <= S_IDLE;
         ack_q     <= 1'b0;
      end else begin
         case (state_q)
            S_ADDR, S_PTR, S_DATA: begin
               if (scl_rise && bit_cnt_q != 4'h8) begin
                  shift_q   <= {shift_q[6:0], sda_s[1]};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_done) begin
                  if (state_q == S_ADDR) begin
                     if (shift_q == {DEV_ADDR_HI, strap_s2, 1'b0}) begin
                        state_q <= S_ACK;
                        next_q  <= S_PTR;
                        ack_q   <= 1'b1;
                     end else begin
                        state_q <= S_IGNORE;
                     end
                  end else if (state_q == S_PTR) begin
                     ptr_q   <= shift_q;
                     state_q <= S_ACK;
                     next_q  <= S_DATA;
                     ack_q   <= 1'b1;
                  end else begin
                     ptr_q   <= ptr_q + 8'h01;
                     state_q <= S_ACK;
                     next_q  <= S_DATA;
                     ack_q   <= 1'b1;
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  ack_q     <= 1'b0;
                  state_q   <= next_q;
                  bit_cnt_q <= 4'h0;
               end
            end
            default: begin
               ack_q <= 1'b0;
            end
         endcase
      end
   end

   // acknowledge driver, open drain
   assign link.sda_o_tgt    = 1'b0;
   assign link.sda_oe_n_tgt = ~ack_q;

   // ==========================================================
   // control registers and shadow storage
   always_ff @(posedge clk_i) begin
      if (rst_i || soft_rst) begin
         soft_shutdown_n_q <= REG_RESET_VAL[0];
         global_off_q      <= REG_RESET_VAL[0];
         pwm_rate_q        <= REG_RESET_VAL[0];
         for (int i = 0; i < CHANNELS; i++) begin
            duty_sh_q[i]  <= REG_RESET_VAL;
            scale_sh_q[i] <= REG_RESET_VAL[5:0];
         end
      end else if (wr_stb) begin
         if (ptr_q == REG_SHUTDOWN) begin
            soft_shutdown_n_q <= shift_q[0];
         end else if (ptr_q >= REG_DUTY_FIRST && ptr_q <= REG_DUTY_LAST) begin
            duty_sh_q[chan_idx(ptr_q, REG_DUTY_FIRST)] <= shift_q;
         end else if (ptr_q >= REG_SCALE_FIRST && ptr_q <= REG_SCALE_LAST) begin
            scale_sh_q[chan_idx(ptr_q, REG_SCALE_FIRST)] <= shift_q[5:0];
         end else if (ptr_q == REG_GLOBAL) begin
            global_off_q <= shift_q[0];
         end else if (ptr_q == REG_FREQ) begin
            pwm_rate_q <= shift_q[0];
         end
      end
   end

   // active copies loaded by the update trigger, cleared by reset or the reset write
   always_ff @(posedge clk_i) begin
      if (rst_i || soft_rst) begin
         for (int i = 0; i < CHANNELS; i++) begin
            duty_act_q[i]  <= REG_RESET_VAL;
            scale_act_q[i] <= REG_RESET_VAL[5:0];
         end
      end else if (upd_stb) begin
         for (int i = 0; i < CHANNELS; i++) begin
            duty_act_q[i]  <= duty_sh_q[i];
            scale_act_q[i] <= scale_sh_q[i];
         end
      end
   end

   // ==========================================================
   // pwm timebase, 256 steps per period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_q   <= 9'h000;
         pwm_cnt_q <= 8'h00;
      end else if (presc_q >= (pwm_rate_q ? STEP_SLOW : STEP_FAST) - 9'h001) begin
         presc_q   <= 9'h000;
         pwm_cnt_q <= pwm_cnt_q + 8'h01;
      end else begin
         presc_q   <= presc_q + 9'h001;
      end
   end

   // shutdown and global disable gate the sink outputs but keep register contents
   assign out_en = soft_shutdown_n_q & hwsd_s[1] & ~global_off_q;

   // registered sink drive
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         led_sink_outputs_o <= '0;
         pwm_rate_select_o  <= 1'b0;
      end else begin
         pwm_rate_select_o <= pwm_rate_q;
         for (int i = 0; i < CHANNELS; i++) begin
            led_sink_outputs_o[i] <= out_en && (duty_act_q[i] > pwm_cnt_q) && scale_on(scale_act_q[i]);
         end
      end
   end
endmodule

/* hdl/led_link_pkg.sv */
// Purpose: shared constants for the led driver serial link and register map
// Assumes: 250 MHz system clock on both ends
// Notes:   byte pointer map of the target, command map of the controller
package led_link_pkg;
   // ==========================================================
   // target address and register pointers
   localparam logic [4:0] DEV_ADDR_HI     = 5'h1b;
   localparam logic [7:0] REG_SHUTDOWN    = 8'h00;
   localparam logic [7:0] REG_DUTY_FIRST  = 8'h04;
   localparam logic [7:0] REG_DUTY_LAST   = 8'h0f;
   localparam logic [7:0] REG_UPDATE      = 8'h13;
   localparam logic [7:0] REG_SCALE_FIRST = 8'h17;
   localparam logic [7:0] REG_SCALE_LAST  = 8'h22;
   localparam logic [7:0] REG_GLOBAL      = 8'h26;
   localparam logic [7:0] REG_FREQ        = 8'h27;
   localparam logic [7:0] REG_SOFT_RESET  = 8'h2f;
   localparam logic [7:0] TRIGGER_VALUE   = 8'h00;
   localparam logic [7:0] REG_RESET_VAL   = 8'h00;
   localparam int         CHANNELS        = 12;
   // ==========================================================
   // current scale codes that drive the sink
   localparam logic [5:0] SCALE_FULL      = 6'h10;
   localparam logic [5:0] SCALE_7_12      = 6'h13;
   // ==========================================================
   // pwm timing
   localparam int         CLK_HZ          = 250_000_000;
   localparam int         CLK_NS          = 4;
   localparam int         PWM_STEPS       = 256;
   localparam int         PWM_FAST_HZ     = 24_000;
   localparam int         PWM_SLOW_HZ     = 3_600;
   localparam logic [8:0] STEP_FAST       = 9'(CLK_HZ / (PWM_FAST_HZ * PWM_STEPS));
   localparam logic [8:0] STEP_SLOW       = 9'(CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS));
   // ==========================================================
   // controller bit timing: quarter of a serial clock period
   localparam int         QUARTER_NS      = 650;
   localparam logic [8:0] QUARTER_CYC     = 9'((QUARTER_NS + CLK_NS - 1) / CLK_NS);
   // ==========================================================
   // controller command registers
   localparam logic [3:0] CMD_OFS         = 4'h0;
   localparam logic [3:0] STAT_OFS        = 4'h4;
   localparam int         CMD_START_BIT   = 8;
   localparam int         CMD_STOP_BIT    = 9;
   localparam int         STAT_BUSY_BIT   = 0;
   localparam int         STAT_NACK_BIT   = 1;
endpackage

/* hdl/led_link_if.sv */
// Purpose: open-drain two-wire link between controller and led target
// Assumes: pull-ups on both lines
// Notes:   a line is low when any driver has its enable low
`timescale 1ns/1ns
interface led_link_if;
   logic scl_o_ctl;
   logic scl_oe_n_ctl;
   logic sda_o_ctl;
   logic sda_oe_n_ctl;
   logic sda_o_tgt;
   logic sda_oe_n_tgt;
   logic scl;
   logic sda;
   // wired-and resolution of the bus
   assign scl = scl_oe_n_ctl ? 1'b1 : scl_o_ctl;
   assign sda = (sda_oe_n_ctl ? 1'b1 : sda_o_ctl) & (sda_oe_n_tgt ? 1'b1 : sda_o_tgt);
   modport ctl (output scl_o_ctl, output scl_oe_n_ctl, output sda_o_ctl, output sda_oe_n_ctl,
                input scl, input sda);
   modport tgt (output sda_o_tgt, output sda_oe_n_tgt, input scl, input sda);
endinterface

/* hdl/led_controller.sv */
// Purpose: two-wire bus controller driven by software over avalon-mm
// Assumes: no clock stretching by the target
// Notes:   one command moves one byte with optional start and stop
`timescale 1ns/1ns
module led_controller
   import led_link_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // link
   led_link_if.ctl          link
);
   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_START = 2'b01,
      H_BITS  = 2'b10,
      H_STOP  = 2'b11
   } ctl_state_e;

   ctl_state_e  state_q;
   logic [8:0]  tick_q;
   logic [1:0]  phase_q;
   logic [3:0]  bit_q;
   logic [8:0]  tx_q;
   logic        stop_q;
   logic        nack_q;
   logic        scl_rel_q;
   logic        sda_rel_q;
   logic        rvalid_q;
   logic [1:0]  sda_s;
   logic        tick;
   logic        cmd_wr;
   logic        busy;

   assign busy              = (state_q != H_IDLE);
   assign tick              = (tick_q == QUARTER_CYC - 9'h001);
   assign cmd_wr            = avs_write_i && !busy && (avs_address_i == CMD_OFS);
   assign avs_waitrequest_o = (avs_read_i && !rvalid_q) || (avs_write_i && busy);

   // ==========================================================
   // read path, one wait cycle then registered data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rvalid_q       <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         rvalid_q <= avs_read_i && !rvalid_q;
         if (avs_read_i && !rvalid_q) begin
            if (avs_address_i == STAT_OFS) begin
               avs_readdata_o <= 32'({nack_q, busy});
            end else begin
               avs_readdata_o <= 32'h0000_0000;
            end
         end
      end
   end

   // data line synchroniser for the acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sda_s <= 2'h3;
      end else begin
         sda_s <= {sda_s[0], link.sda};
      end
   end

   // quarter period timer
   always_ff @(posedge clk_i) begin
      if (rst_i || !busy || tick) begin
         tick_q <= 9'h000;
      end else begin
         tick_q <= tick_q + 9'h001;
      end
   end

   // ==========================================================
   // bus sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q   <= H_IDLE;
         phase_q   <= 2'h0;
         bit_q     <= 4'h0;
         tx_q      <= 9'h1ff;
         stop_q    <= 1'b0;
         nack_q    <= 1'b0;
         scl_rel_q <= 1'b1;
         sda_rel_q <= 1'b1;
      end else if (cmd_wr) begin
         // address bytes always go out with the write bit
         tx_q    <= {avs_writedata_i[7:1], avs_writedata_i[0] & ~avs_writedata_i[CMD_START_BIT], 1'b1};
         stop_q  <= avs_writedata_i[CMD_STOP_BIT];
         bit_q   <= 4'h0;
         phase_q <= 2'h0;
         state_q <= avs_writedata_i[CMD_START_BIT] ? H_START : H_BITS;
      end else if (tick) begin
         phase_q <= phase_q + 2'h1;
         case (state_q)
            H_START: begin
               case (phase_q)
                  2'h0: sda_rel_q <= 1'b1;
                  2'h1: scl_rel_q <= 1'b1;
                  2'h2: sda_rel_q <= 1'b0;
                  default: begin
                     scl_rel_q <= 1'b0;
                     state_q   <= H_BITS;
                  end
               endcase
            end
            H_BITS: begin
               case (phase_q)
                  2'h0: begin
                     scl_rel_q <= 1'b0;
                     sda_rel_q <= tx_q[8];
                  end
                  2'h1: scl_rel_q <= 1'b1;
                  2'h2: begin
                     if (bit_q == 4'h8) begin
                        nack_q <= sda_s[1];
                     end
                  end
                  default: begin
                     scl_rel_q <= 1'b0;
                     tx_q      <= {tx_q[7:0], 1'b1};
                     bit_q     <= bit_q + 4'h1;
                     if (bit_q == 4'h8) begin
                        // a missing acknowledge always ends the transfer
                        state_q <= (stop_q || nack_q) ? H_STOP : H_IDLE;
                     end
                  end
               endcase
            end
            H_STOP: begin
               case (phase_q)
                  2'h0: sda_rel_q <= 1'b0;
                  2'h1: scl_rel_q <= 1'b1;
                  2'h2: sda_rel_q <= 1'b1;
                  default: state_q <= H_IDLE;
               endcase
            end
            default: phase_q <= 2'h0;
         endcase
      end
   end

   // open-drain drive, enable low pulls the line
   assign link.scl_o_ctl    = 1'b0;
   assign link.scl_oe_n_ctl = scl_rel_q;
   assign link.sda_o_ctl    = 1'b0;
   assign link.sda_oe_n_ctl = sda_rel_q;
endmodule

/* sim/led_link_chk.sv */
// Purpose: timing checks on the two-wire link between both ends
// Assumes: one clock domain, synchronous active high reset
// Notes:   sees only the interface signals
`timescale 1ns/1ns
module led_link_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link enables and resolved lines
   input wire logic scl_oe_n_ctl,
   input wire logic sda_oe_n_ctl,
   input wire logic sda_oe_n_tgt,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ==========================================================
   // target acknowledge
   property p_ack_entry;
      $fell(sda_oe_n_tgt) |-> !scl;
   endproperty
   a_ack_entry: assert property (p_ack_entry) else $error("ack began with clock high");
   property p_ack_window;
      $fell(sda_oe_n_tgt) |-> (!sda_oe_n_tgt)[*8] ##[1:700] sda_oe_n_tgt;
   endproperty
   a_ack_window: assert property (p_ack_window) else $error("ack too short or never released");
   property p_ack_hold;
      !sda_oe_n_tgt && $fell(scl) |-> ##1 !sda_oe_n_tgt;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped at clock fall");
   property p_tgt_stable;
      scl && $past(scl) |-> $stable(sda_oe_n_tgt);
   endproperty
   a_tgt_stable: assert property (p_tgt_stable) else $error("target moved data while clock high");
   // ==========================================================
   // controller framing, and release of all three enables after reset
   property p_bit_stable;
      $rose(scl) |-> ($stable(sda_oe_n_ctl) && scl)[*8];
   endproperty
   a_bit_stable: assert property (p_bit_stable) else $error("data moved just after clock rise");
   property p_start_low;
      $fell(sda_oe_n_ctl) && scl |-> ##[1:200] !scl;
   endproperty
   a_start_low: assert property (p_start_low) else $error("clock not lowered after start");
   property p_stop_idle;
      $rose(sda) && $past(scl) && scl |-> scl[*8];
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("clock moved after stop");
   property p_reset_idle;
      $fell(rst_i) |-> scl_oe_n_ctl && sda_oe_n_ctl && sda_oe_n_tgt;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("lines not released after reset");
endmodule

/* sim/led_driver_i2c_write_regs_tb.sv */
// Purpose: bench for controller and led target joined over the link
// Assumes: strap code 10, package bit timing
// Notes:   software side over avalon, results judged at sinks and wires
`timescale 1ns/1ns
module led_driver_i2c_write_regs_tb
   import led_link_pkg::*;
;
   // ==========================================================
   // stimulus and observed signals
   logic                clk_i = 1'b0;
   logic                rst_i = 1'b1;
   logic [3:0]          avs_address = 4'h0;
   logic                avs_read = 1'b0;
   logic                avs_write = 1'b0;
   logic [31:0]         avs_writedata = 32'h0;
   logic [31:0]         avs_readdata;
   logic                avs_waitrequest;
   logic [1:0]          strap = 2'b10;
   logic                hw_shutdown_n = 1'b1;
   logic [CHANNELS-1:0] led_out;
   logic                rate_sel;
   logic                scl_d = 1'b1;
   logic                sda_d = 1'b1;
   logic [8:0]          frame_q = 9'h0;
   logic [8:0]          first_q = 9'h0;
   int                  nbit = 0;
   int                  n_mismatch = 0;
   int                  num_checks = 0;
   localparam logic [7:0] DEV   = {DEV_ADDR_HI, 2'b10, 1'b0};
   localparam logic [7:0] OTHER = {DEV_ADDR_HI, 2'b01, 1'b0};
   // start and stop flags then byte
   // ch3 gets a duty but keeps its off scale code
   logic [9:0]          seq [15] = '{{2'b10, DEV}, {2'b00, REG_SHUTDOWN}, {2'b01, 8'h01},
      {2'b10, DEV}, {2'b00, REG_DUTY_FIRST}, {2'b00, 8'hff}, {2'b00, 8'h80}, {2'b01, 8'h40},
      {2'b10, DEV}, {2'b00, REG_SCALE_FIRST}, {4'h0, SCALE_FULL}, {4'h4, SCALE_7_12},
      {2'b10, DEV}, {2'b00, REG_UPDATE}, {2'b01, TRIGGER_VALUE}};
   // clock
   always #2 clk_i = ~clk_i;
   // ==========================================================
   // both ends and the checker
   led_link_if link ();
   led_controller led_controller_inst (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address),
      .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
      .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .link(link));
   led_target led_target_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .addr_strap_i(strap),
      .hw_shutdown_n_i(hw_shutdown_n), .led_sink_outputs_o(led_out), .pwm_rate_select_o(rate_sel));
   led_link_chk led_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .scl_oe_n_ctl(link.scl_oe_n_ctl),
      .sda_oe_n_ctl(link.sda_oe_n_ctl), .sda_oe_n_tgt(link.sda_oe_n_tgt), .scl(link.scl), .sda(link.sda));
   // wire monitor: first nine bits after each start
   always @(posedge clk_i) begin
      scl_d <= link.scl;
      sda_d <= link.sda;
      if (scl_d && link.scl && sda_d && !link.sda) begin
         nbit <= 0;
      end else if (!scl_d && link.scl) begin
         frame_q <= {frame_q[7:0], link.sda};
         nbit <= nbit + 1;
         if (nbit == 8) begin
            first_q <= {frame_q[7:0], link.sda};
         end
      end
   end
   // ==========================================================
   // shared tasks
   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic fail_wait(input string what);
      n_mismatch++;
      $display("BAD %s expected done seen timeout", what);
      tally_and_finish();
   endtask
   task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20000);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 20000) fail_wait("avalon");
      @(posedge clk_i);
   endtask
   task automatic send_byte(input logic [7:0] b, input logic st, input logic sp, input logic nack);
      logic [31:0] q;
      int          n;
      av_xfer(1'b1, CMD_OFS, {22'h0, sp, st, b}, q);
      n = 0;
      do begin
         av_xfer(1'b0, STAT_OFS, 32'h0, q);
         n++;
      end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 5000);
      if (n >= 5000) fail_wait("byte");
      check_val("byte nack", {31'h0, nack}, {31'h0, q[STAT_NACK_BIT]});
   endtask
   task automatic count_on(input int cycles, output int c1, output int c2, output int rest);
      c1 = 0;
      c2 = 0;
      rest = 0;
      repeat (cycles) begin
         @(posedge clk_i);
         c1 += int'(led_out[0] === 1'b1);
         c2 += int'(led_out[1] === 1'b1);
         rest += int'(led_out[CHANNELS-1:2] !== '0);
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic test_idle;
      logic [31:0] q;
      check_val("idle lines", 32'h3, {30'h0, link.scl, link.sda});
      av_xfer(1'b0, 4'h8, 32'h0, q);
      check_val("unmapped read", 32'h0, q);
      check_val("sinks after reset", 32'h0, {19'h0, rate_sel, led_out});
      $display("test idle done");
   endtask
   task automatic test_wrong_addr;
      send_byte(OTHER, 1'b1, 1'b0, 1'b1);
      check_val("foreign address wire", {23'h0, OTHER, 1'b1}, {23'h0, first_q});
      check_val("lines after abort", 32'h3, {30'h0, link.scl, link.sda});
      $display("test wrong address done");
   endtask
   task automatic test_write_path;
      int c1;
      int c2;
      int rest;
      for (int i = 0; i < 15; i++) begin
         if (i == 12) begin
            count_on(64, c1, c2, rest);
            check_val("sinks before update", 32'h0, 32'(c1 + c2 + rest));
         end
         send_byte(seq[i][7:0], seq[i][9], seq[i][8], 1'b0);
         if (i == 0) check_val("address wire", {23'h0, DEV, 1'b0}, {23'h0, first_q});
      end
      count_on(PWM_STEPS * STEP_FAST, c1, c2, rest);
      check_val("ch1 on cycles", 32'(255 * STEP_FAST), 32'(c1));
      check_val("ch2 on cycles", 32'(128 * STEP_FAST), 32'(c2));
      check_val("unscaled channels", 32'h0, 32'(rest));
      check_val("rate select", 32'h0, {31'h0, rate_sel});
      $display("test write path done");
   endtask
   task automatic test_hw_shutdown;
      int c1;
      int c2;
      int rest;
      hw_shutdown_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      count_on(64, c1, c2, rest);
      check_val("sinks in shutdown", 32'h0, 32'(c1 + c2 + rest));
      hw_shutdown_n <= 1'b1;
      count_on(256, c1, c2, rest);
      check_val("ch1 after wake", 32'h1, {31'h0, c1 > 200});
      $display("test shutdown done");
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      test_idle();
      test_wrong_addr();
      test_write_path();
      test_hw_shutdown();
      tally_and_finish();
   end
endmodule
